// ==== adc_conversion_control.sv ====
// Overview of operation
// - start bit rising then falling launches conversion
// - while start high, hold core reset, busy
// - hardware clears busy flag at conversion end
// - completion sets request flag; masked interrupt out
// - divider field selects sys clock divide 1..64
// - core powered only while power-down bit zero
// - power stays on with no pins selected
// - reference select picks supply or reference pin
// - pin enable makes pin analog, kills digital
// - analog pin drops its pull-up
// - analog pin overrides port direction
// - conversion lasts sixteen conversion clock periods
// - align bit picks left/right result placement
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_conversion_control
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire adc_ctrl_pkg::reg_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output adc_ctrl_pkg::reg_byte_t reg_rdata,
  // Interrupt
  output logic irq,
  // Analog core
  input wire logic [11:0] core_sample,
  output logic core_reset,
  output logic core_power_on,
  output logic core_clock_tick,
  output logic reference_source_sel,
  // Pin muxing
  input wire logic [7:0] pin_pullup_en,
  input wire logic [7:0] port_direction_reg,
  output logic [7:0] analog_pin_enables,
  output logic [7:0] pin_digital_en,
  output logic [7:0] pin_pullup_active,
  output logic [7:0] pin_input_dir,
  output logic vref_pin_digital_en
);
  import adc_ctrl_pkg::*;

  logic rst_meta, rst_sync_n;
  logic start_bit, conv_power_down, result_align_sel;
  logic [2:0] conv_clock_divider_sel;
  logic ref_sel;
  logic [7:0] pin_sel;
  logic conv_busy_flag;
  logic irq_stat, irq_mask;
  conv_state_t state;
  logic [4:0] periods;
  logic div_tick;
  logic [7:0] result_hi, result_lo;
  logic [11:0] sample_sync1, sample_sync2;
  logic [7:0] pullup_s1, pullup_s2, dir_s1, dir_s2;

  wire logic wr_c0, wr_c1, wr_pin, wr_mask, rd_stat;
  wire logic start_rise, start_fall, conv_done, div_run;
  wire reg_byte_t ctrl0_val, ctrl1_val, read_mux;

  // Reset release through two stages
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  // Pin-side levels and core sample come from outside this domain
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      sample_sync1 <= 12'h000;
      sample_sync2 <= 12'h000;
      pullup_s1 <= 8'h00;
      pullup_s2 <= 8'h00;
      dir_s1 <= 8'h00;
      dir_s2 <= 8'h00;
    end else begin
      sample_sync1 <= core_sample;
      sample_sync2 <= sample_sync1;
      pullup_s1 <= pin_pullup_en;
      pullup_s2 <= pullup_s1;
      dir_s1 <= port_direction_reg;
      dir_s2 <= dir_s1;
    end
  end

  assign wr_c0 = reg_write && reg_addr == `ADDR_CTRL0;
  assign wr_c1 = reg_write && reg_addr == `ADDR_CTRL1;
  assign wr_pin = reg_write && reg_addr == `ADDR_PINSEL;
  assign wr_mask = reg_write && reg_addr == `ADDR_IRQ_MASK;
  assign rd_stat = reg_read && reg_addr == `ADDR_IRQ_STAT;

  assign start_rise = wr_c0 && !start_bit && reg_wdata[`C0_START];
  assign start_fall = wr_c0 && start_bit && !reg_wdata[`C0_START];

  // sixteen conversion periods end the cycle
  assign conv_done = state == st_convert && div_tick &&
    periods == `CONV_PERIODS - 5'h01;
  assign div_run = state == st_convert && !conv_power_down;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_bit <= 1'b0;
      conv_power_down <= `RST_PDOWN;
      result_align_sel <= 1'b0;
      conv_clock_divider_sel <= `RST_DIV;
      ref_sel <= 1'b0;
      pin_sel <= `RST_PINSEL;
      irq_mask <= 1'b0;
    end else begin
      if (wr_c0) begin
        start_bit <= reg_wdata[`C0_START];
        conv_power_down <= reg_wdata[`C0_PDOWN];
        result_align_sel <= reg_wdata[`C0_ALIGN];
      end
      if (wr_c1) begin
        ref_sel <= reg_wdata[`C1_VREF];
        conv_clock_divider_sel <= reg_wdata[`C1_DIV_HI:`C1_DIV_LO];
      end
      if (wr_pin)
        pin_sel <= reg_wdata;
      if (wr_mask)
        irq_mask <= reg_wdata[0];
    end
  end

  // Conversion sequencer
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= st_idle;
      periods <= 5'h00;
      conv_busy_flag <= 1'b1;
    end else begin
      case (state)
        st_idle: begin
          // start raised resets and sets busy
          if (start_rise) begin
            state <= st_reset;
            conv_busy_flag <= 1'b1;
          end
        end
        st_reset: begin
          if (start_fall) begin
            state <= st_convert;
            periods <= 5'h00;
          end
        end
        st_convert: begin
          if (start_rise) begin
            state <= st_reset;
          end else if (conv_done) begin
            state <= st_idle;
            conv_busy_flag <= 1'b0;
          end else if (div_tick) begin
            periods <= periods + 5'h01;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  conv_clock_divider #(.DIV_W(6)) u_div (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .conv_clock_divider_sel(conv_clock_divider_sel),
    .run(div_run),
    .tick(div_tick)
  );

  // result placement, loaded with busy fall
  result_format u_fmt (
    .sys_clk(sys_clk),
    .rst_n(rst_sync_n),
    .load(conv_done),
    .align_right(result_align_sel),
    .sample(sample_sync2),
    .result_hi(result_hi),
    .result_lo(result_lo)
  );

  // sticky request flag; set beats read clear
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      irq_stat <= 1'b0;
      irq <= 1'b0;
    end else begin
      irq_stat <= conv_done || (irq_stat && !rd_stat);
      irq <= (conv_done || (irq_stat && !rd_stat)) && irq_mask;
    end
  end

  assign ctrl0_val = {start_bit, conv_busy_flag, conv_power_down,
    result_align_sel, 4'h0};
  assign ctrl1_val = {3'h0, ref_sel, 1'b0, conv_clock_divider_sel};
  assign read_mux =
    reg_addr == `ADDR_CTRL0 ? ctrl0_val :
    reg_addr == `ADDR_CTRL1 ? ctrl1_val :
    reg_addr == `ADDR_PINSEL ? pin_sel :
    reg_addr == `ADDR_RES_HI ? result_hi :
    reg_addr == `ADDR_RES_LO ? result_lo :
    reg_addr == `ADDR_IRQ_STAT ? {7'h00, irq_stat} :
    reg_addr == `ADDR_IRQ_MASK ? {7'h00, irq_mask} : 8'h00;

  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n)
      reg_rdata <= 8'h00;
    else
      reg_rdata <= reg_read ? read_mux : 8'h00;
  end

  // Core and pin controls, all registered
  always_ff @(posedge sys_clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      core_reset <= 1'b1;
      core_power_on <= 1'b0;
      core_clock_tick <= 1'b0;
      reference_source_sel <= 1'b0;
      vref_pin_digital_en <= 1'b1;
      analog_pin_enables <= `RST_PINSEL;
      pin_digital_en <= 8'h00;
      pin_pullup_active <= 8'h00;
      pin_input_dir <= 8'hff;
    end else begin
      core_reset <= state != st_convert;
      core_power_on <= !conv_power_down;
      core_clock_tick <= div_tick;
      // reference pin takes over its shared pin
      reference_source_sel <= ref_sel;
      vref_pin_digital_en <= !ref_sel;
      analog_pin_enables <= pin_sel;
      pin_digital_en <= ~pin_sel;
      pin_pullup_active <= pullup_s2 & ~pin_sel;
      pin_input_dir <= dir_s2 | pin_sel;
    end
  end
endmodule // adc_conversion_control

// ==== adc_ctrl_defs.svh ====
`ifndef ADC_CTRL_DEFS_SVH
`define ADC_CTRL_DEFS_SVH

// Register indices on the plain port
`define ADDR_CTRL0 3'h0
`define ADDR_CTRL1 3'h1
`define ADDR_PINSEL 3'h2
`define ADDR_RES_HI 3'h3
`define ADDR_RES_LO 3'h4
`define ADDR_IRQ_STAT 3'h5
`define ADDR_IRQ_MASK 3'h6

// Control register 0 fields
`define C0_START 7
`define C0_BUSY 6
`define C0_PDOWN 5
`define C0_ALIGN 4
// Control register 1 fields
`define C1_VREF 4
`define C1_DIV_HI 2
`define C1_DIV_LO 0

// Reset values
`define RST_PDOWN 1'b1
`define RST_PINSEL 8'hff
`define RST_DIV 3'h0

// Conversion length in conversion clock periods
`define CONV_PERIODS 5'h10
`define DIV_UNDEF 3'h7

`endif

// ==== adc_ctrl_pkg.sv ====
package adc_ctrl_pkg;
  typedef enum logic [1:0] {
    st_idle,
    st_reset,
    st_convert
  } conv_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// ==== conv_clock_divider.sv ====
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module conv_clock_divider #(
  parameter int DIV_W = 6
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Control
  input wire logic [2:0] conv_clock_divider_sel,
  input wire logic run,
  // Tick
  output logic tick
);
  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] limit;
  wire logic undef_sel;

  // Setting 7 is undefined: the clock stops rather than guess
  assign undef_sel = conv_clock_divider_sel == `DIV_UNDEF;
  assign limit = DIV_W'((7'h01 << conv_clock_divider_sel) - 7'h01);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else if (!run || undef_sel) begin
      count <= '0;
      tick <= 1'b0;
    end else if (count >= limit) begin
      count <= '0;
      tick <= 1'b1;
    end else begin
      count <= count + DIV_W'(1);
      tick <= 1'b0;
    end
  end
endmodule // conv_clock_divider

// ==== result_format.sv ====
`timescale 1ns/1ps
module result_format (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Capture
  input wire logic load,
  input wire logic align_right,
  input wire logic [11:0] sample,
  // Result bytes
  output logic [7:0] result_hi,
  output logic [7:0] result_lo
);
  wire logic [15:0] placed;

  assign placed = align_right ? {4'h0, sample} : {sample, 4'h0};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_hi <= 8'h00;
      result_lo <= 8'h00;
    end else if (load) begin
      result_hi <= placed[15:8];
      result_lo <= placed[7:0];
    end
  end
endmodule // result_format

// ==== adc_core_model.sv ====
`timescale 1ns/1ps
module adc_core_model #(
  parameter logic [11:0] SAMPLE = 12'ha5c
) (
  // Clock
  input wire logic sys_clk,
  // Core control
  input wire logic core_reset,
  input wire logic core_power_on,
  // Result
  output logic [11:0] core_sample
);
  logic [11:0] junk = 12'h000;
  always_ff @(posedge sys_clk) begin
    junk <= ~junk;
  end
  // result only while powered
  // Outside a conversion the lines toggle so stale data cannot pass
  assign core_sample = (core_reset || !core_power_on) ? junk : SAMPLE;
endmodule // adc_core_model

// ==== adc_conversion_control_chk.sv ====
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module adc_conversion_control_chk
  import adc_ctrl_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire adc_ctrl_pkg::reg_byte_t reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire adc_ctrl_pkg::reg_byte_t reg_rdata,
  // Core and pins
  input wire logic irq,
  input wire logic core_reset,
  input wire logic core_power_on,
  input wire logic core_clock_tick,
  input wire logic reference_source_sel,
  input wire logic [7:0] analog_pin_enables,
  input wire logic [7:0] pin_digital_en,
  input wire logic [7:0] pin_pullup_active,
  input wire logic [7:0] pin_input_dir,
  input wire logic vref_pin_digital_en
);
  logic [4:0] ticks;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n || core_reset) begin
      ticks <= 5'h00;
    end else if (core_clock_tick) begin
      ticks <= ticks + 5'h01;
    end
  end
  sequence start_wr;
    reg_write && reg_addr == `ADDR_CTRL0 && reg_wdata[`C0_START];
  endsequence
  chk_start_reset: assert property (start_wr |-> ##[1:2] core_reset)
    else $error("core not reset after start");
  chk_off_no_tick: assert property (!core_power_on |-> !core_clock_tick)
    else $error("tick while powered down");
  chk_conv_min: assert property ($rose(core_reset) |-> ticks >= 5'h0f)
    else $error("conversion too short");
  chk_conv_max: assert property (ticks <= 5'h10)
    else $error("conversion too long");
  chk_digital_off: assert property (pin_digital_en == ~analog_pin_enables)
    else $error("digital enable wrong");
  chk_dir_override: assert property (
    (pin_input_dir & analog_pin_enables) == analog_pin_enables)
    else $error("analog pin not input");
  chk_pullup_drop: assert property (((pin_pullup_active & analog_pin_enables)
    & $past(analog_pin_enables, 3)) == 8'h00)
    else $error("pull-up on analog pin");
  chk_vref_share: assert property (
    vref_pin_digital_en == !reference_source_sel)
    else $error("reference pin still digital");
  chk_irq_done: assert property ($rose(irq) |-> ##1 core_reset)
    else $error("irq without completion");
  chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
endmodule // adc_conversion_control_chk
bind adc_conversion_control adc_conversion_control_chk u_chk (
  .sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .irq, .core_reset, .core_power_on, .core_clock_tick,
  .reference_source_sel, .analog_pin_enables, .pin_digital_en,
  .pin_pullup_active, .pin_input_dir, .vref_pin_digital_en
);

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "adc_ctrl_defs.svh"
module testbench;
  import adc_ctrl_pkg::*;
  typedef struct packed {
    logic [7:0] sel, pu, dir, dig, pua, idir;
  } pin_row_t;
  pin_row_t rows [3] = '{'{8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff},
    '{8'h3c, 8'hff, 8'h81, 8'hc3, 8'hc3, 8'hbd},
    '{8'h00, 8'ha5, 8'h0f, 8'hff, 8'ha5, 8'h0f}};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] reg_addr = 3'h0;
  reg_byte_t reg_wdata = 8'h00;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [7:0] pin_pullup_en = 8'h00;
  logic [7:0] port_direction_reg = 8'h00;
  reg_byte_t reg_rdata, d;
  logic irq, core_reset, core_power_on, core_clock_tick;
  logic reference_source_sel, vref_pin_digital_en;
  logic [11:0] core_sample;
  logic [7:0] analog_pin_enables, pin_digital_en;
  logic [7:0] pin_pullup_active, pin_input_dir;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;
  adc_conversion_control u_adc_conversion_control (.sys_clk, .rst_n,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .irq,
    .core_sample, .core_reset, .core_power_on, .core_clock_tick,
    .reference_source_sel, .pin_pullup_en, .port_direction_reg,
    .analog_pin_enables, .pin_digital_en, .pin_pullup_active,
    .pin_input_dir, .vref_pin_digital_en);
  adc_core_model u_adc_core_model (.sys_clk, .core_reset, .core_power_on,
    .core_sample);
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  task automatic stop_test();
    if (err_total == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic chk(input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t exp=%h got=%h", $time, exp, got);
      err_total++;
    end
  endtask
  task automatic wr(input logic [2:0] a, input reg_byte_t v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output reg_byte_t v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic conv(input logic [2:0] sel, input logic al,
                      input reg_byte_t hi, input reg_byte_t lo);
    wr(`ADDR_CTRL1, {5'h00, sel});
    wr(`ADDR_CTRL0, {3'h4, al, 4'h0});
    rd(`ADDR_CTRL0, d);
    chk(16'h1, 16'(d[6]));
    wr(`ADDR_CTRL0, {3'h0, al, 4'h0});
    @(posedge sys_clk iff core_clock_tick);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (!core_clock_tick && n < 200);
    chk(16'(1 << sel), 16'(n));
    n = 0;
    do begin
      rd(`ADDR_CTRL0, d);
      n++;
    end while (d[6] && n < 1000);
    chk(16'h0, 16'(d[6]));
    rd(`ADDR_RES_HI, d);
    chk(16'(hi), 16'(d));
    rd(`ADDR_RES_LO, d);
    chk(16'(lo), 16'(d));
  endtask
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 chk(16'hff00, {analog_pin_enables, pin_digital_en});
    chk(16'h0100, {7'h0, core_reset, 7'h0, core_power_on});
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd(`ADDR_CTRL0, d);
    chk(16'h60, 16'(d));
    rd(`ADDR_PINSEL, d);
    chk(16'hff, 16'(d));
    rd(3'h7, d);
    chk(16'h00, 16'(d));
    foreach (rows[i]) begin
      pin_pullup_en <= rows[i].pu;
      port_direction_reg <= rows[i].dir;
      wr(`ADDR_PINSEL, rows[i].sel);
      repeat (4) @(posedge sys_clk);
      #1 chk({rows[i].dig, rows[i].pua}, {pin_digital_en, pin_pullup_active});
      chk({rows[i].sel, rows[i].idir}, {analog_pin_enables, pin_input_dir});
    end
    wr(`ADDR_CTRL1, 8'h10);
    repeat (2) @(posedge sys_clk);
    #1 chk(16'h2, {14'h0, reference_source_sel, vref_pin_digital_en});
    wr(`ADDR_CTRL0, 8'h00);
    repeat (10) @(posedge sys_clk);
    #1 chk(16'h1, 16'(core_power_on));
    wr(`ADDR_IRQ_MASK, 8'h01);
    conv(3'h0, 1'b0, 8'ha5, 8'hc0);
    chk(16'h1, 16'(irq));
    rd(`ADDR_IRQ_STAT, d);
    chk(16'h01, {7'h0, irq, d});
    wr(`ADDR_IRQ_MASK, 8'h00);
    conv(3'h2, 1'b1, 8'h0a, 8'h5c);
    rd(`ADDR_IRQ_STAT, d);
    chk(16'h01, {7'h0, irq, d});
    conv(3'h6, 1'b1, 8'h0a, 8'h5c);
    wr(`ADDR_CTRL0, 8'h20);
    repeat (3) @(posedge sys_clk);
    #1 chk(16'h0, 16'(core_power_on));
    stop_test();
  end
endmodule // testbench
